// ---- inc/param_seq_map.vh ----
/*
  register map, field positions, reset values and limits of the
  parameter set sequencer.
  assumes: plain register port, 8-bit word address, 32-bit data.
*/
// Contract
// - set governs only after copy into active
// - set changes tied to frame trigger
// - auto scheme steps rising index, recycles
// - each set used its repeat count
// - after highest set wrap to index 0
// - set count held, at most 64 sets
// - controlled scheme gated by selectable source
// - free selection picks set from lines
// - restart by line or software command
// - skip command bypasses next set
// - input lines sampled only at trigger
// - software commands act without trigger
// - tag each frame with its set index
// - recall copies selected set into active
// - enabling loads set 0 into active
// - disable finishes frame, restores old values
// - repeat counts limited to 1..256
`ifndef PARAM_SEQ_MAP_VH
`define PARAM_SEQ_MAP_VH

// register word addresses
`define ADDR_CTRL 8'h00
`define ADDR_COUNT 8'h01
`define ADDR_SEL 8'h02
`define ADDR_CMD 8'h03
`define ADDR_REPEAT 8'h04
`define ADDR_STATUS 8'h05
`define ADDR_PARAM 8'h06
`define ADDR_ACTIVE 8'h07

// control fields
`define CTRL_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_SRC_LO 3
`define CTRL_SRC_HI 4
`define CTRL_TAG 5
`define CTRL_RST_LINE 6

// command bits (write one to fire)
`define CMD_ADVANCE 0
`define CMD_RESTART 1
`define CMD_SKIP 2
`define CMD_RECALL 3
`define CMD_STORE 4

// scheme codes
`define MODE_AUTO 2'h0
`define MODE_CTRL 2'h1
`define MODE_FREE 2'h2

// advance source codes
`define SRC_ALWAYS 2'h0
`define SRC_LINE 2'h1
`define SRC_OFF 2'h2

// limits and reset values
`define MAX_SETS 7'h40
`define REPEAT_MIN 9'h001
`define REPEAT_MAX 9'h100
`define COUNT_RST 7'h01
`define REPEAT_RST 9'h001

`endif

// ---- design/set_store.v ----
/*
  parameter set store: one word of sequence parameters plus a
  repeat count for each set, a write port and a read port.
  assumes: caller limits index to the configured depth.
*/
`timescale 1ns/100ps
`default_nettype none
module set_store #(
  parameter DEPTH = 64,
  parameter AW = 6,
  parameter DW = 32
) (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire [DW-1:0] wr_param,
  input wire [8:0] wr_repeat,
  // read side, registered
  input wire [AW-1:0] rd_idx,
  output reg [DW-1:0] rd_param,
  output reg [8:0] rd_repeat
);
  // storage arrays; contents undefined until stored, as in a real ram
  reg [DW-1:0] param_mem [0:DEPTH-1];
  reg [8:0] repeat_mem [0:DEPTH-1];

  // write then registered read
  always @(posedge clk) begin
    if (wr_en) begin
      param_mem[wr_idx] <= wr_param;
      repeat_mem[wr_idx] <= wr_repeat;
    end
    rd_param <= param_mem[rd_idx];
    rd_repeat <= repeat_mem[rd_idx];
  end
endmodule // set_store
`default_nettype wire

// ---- design/param_set_sequencer.v ----
/*
  parameter set sequencer: chooses the stored set loaded into the
  active configuration for each frame, in auto, controlled or free
  selection scheme, with restart, skip, recall and frame tagging.
  assumes: frame_start is a one-cycle pulse per frame, frame_done a
  one-cycle pulse when a frame has been sent, lines synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "param_seq_map.vh"
module param_set_sequencer #(
  parameter DW = 32,
  parameter LINES = 6
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // frame side
  input wire frame_start,
  input wire frame_done,
  input wire [LINES-1:0] in_lines,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // active configuration and frame tag
  output reg [DW-1:0] active_param_r,
  output reg [5:0] cur_idx_r,
  output reg [5:0] frame_tag_r,
  output reg frame_tag_valid_r
);
  // clamp a repeat count into the legal range
  function [8:0] clamp_rep;
    input [31:0] v;
    begin
      if (v < {23'h0, `REPEAT_MIN})
        clamp_rep = `REPEAT_MIN;
      else if (v > {23'h0, `REPEAT_MAX})
        clamp_rep = `REPEAT_MAX;
      else
        clamp_rep = v[8:0];
    end
  endfunction

  // next index in a cycle, wrapping at the set count
  function [5:0] next_idx;
    input [5:0] i;
    input [6:0] n;
    begin
      if ({1'b0, i} + 7'h01 >= n)
        next_idx = 6'h00;
      else
        next_idx = i + 6'h01;
    end
  endfunction

  // software registers
  reg en_r;
  reg [1:0] mode_r;
  reg [1:0] src_r;
  reg tag_en_r;
  reg [2:0] rst_line_r; // line used for synchronous restart
  reg [6:0] count_r; // sets per cycle
  reg [5:0] sel_r; // set selector for store and recall
  reg [8:0] rep_hold_r; // repeat count to store
  reg [DW-1:0] param_hold_r; // parameter word to store
  reg [DW-1:0] saved_r; // active values from before enabling
  reg [8:0] uses_r; // uses of the current set
  reg [8:0] st_repeat_cur; // repeat count of the set currently applied
  reg stop_pend_r; // disable seen, stop waits until any open frame is sent
  reg in_frame_r;
  reg run_r;
  reg load_pend_r; // store read in flight, apply next cycle
  reg [5:0] load_idx_r;
  reg [2:0] sw_cmd_r; // pending advance, restart, skip

  // store read address and result
  reg [5:0] rd_idx;
  wire [DW-1:0] st_param;
  wire [8:0] st_repeat;
  wire st_wr = wr && (addr == `ADDR_CMD) && wdata[`CMD_STORE] && !en_r;
  wire [1:0] line_sel = src_r; // unused decode avoided

  set_store #(.DEPTH(64), .AW(6), .DW(DW)) u_store (
    .clk(clk),
    .wr_en(st_wr),
    .wr_idx(sel_r),
    .wr_param(param_hold_r),
    .wr_repeat(rep_hold_r),
    .rd_idx(rd_idx),
    .rd_param(st_param),
    .rd_repeat(st_repeat)
  );

  // free selection index from input lines, limited to the set count
  wire [5:0] free_raw = in_lines[5:0];
  wire [5:0] free_idx = ({1'b0, free_raw} < count_r) ? free_raw : 6'h00;
  // advance gate in controlled scheme, line 0 as advance line
  wire gate_ok = (src_r == `SRC_ALWAYS) ||
                 ((src_r == `SRC_LINE) && in_lines[0]);
  wire line_rst = in_lines[rst_line_r];
  wire enable_wr = wr && (addr == `ADDR_CTRL);
  wire en_rise = enable_wr && wdata[`CTRL_EN] && !en_r;

  // decision on what set to load this cycle
  reg do_load;
  reg [5:0] tgt;
  reg clr_sw;
  always @* begin
    do_load = 1'b0;
    tgt = cur_idx_r;
    clr_sw = 1'b0;
    rd_idx = sel_r;
    if (en_rise) begin
      do_load = 1'b1;
      tgt = 6'h00;
    end else if (run_r && sw_cmd_r != 3'h0 && mode_r != `MODE_FREE) begin
      clr_sw = 1'b1;
      do_load = 1'b1;
      if (sw_cmd_r[1])
        tgt = 6'h00;
      else if (sw_cmd_r[2])
        tgt = next_idx(next_idx(cur_idx_r, count_r), count_r);
      else
        tgt = next_idx(cur_idx_r, count_r);
    end else if (run_r && frame_start) begin
      case (mode_r)
        `MODE_AUTO: begin
          if (uses_r >= st_repeat_cur) begin
            do_load = 1'b1;
            tgt = next_idx(cur_idx_r, count_r);
          end
        end
        `MODE_CTRL: begin
          if (line_rst && (cur_idx_r != 6'h00 || uses_r != 9'h0)) begin
            do_load = 1'b1;
            tgt = 6'h00;
          end else if (gate_ok && uses_r != 9'h0) begin
            do_load = 1'b1;
            tgt = next_idx(cur_idx_r, count_r);
          end
        end
        `MODE_FREE: begin
          if (free_idx != cur_idx_r) begin
            do_load = 1'b1;
            tgt = free_idx;
          end
        end
        default: do_load = 1'b0;
      endcase
    end
    if (do_load)
      rd_idx = tgt;
  end

  // sequencing state, active configuration and registers
  always @(posedge clk) begin
    if (reset) begin
      en_r <= 1'b0;
      mode_r <= `MODE_AUTO;
      src_r <= `SRC_ALWAYS;
      tag_en_r <= 1'b0;
      rst_line_r <= 3'h1;
      count_r <= `COUNT_RST;
      sel_r <= 6'h00;
      rep_hold_r <= `REPEAT_RST;
      param_hold_r <= {DW{1'b0}};
      saved_r <= {DW{1'b0}};
      active_param_r <= {DW{1'b0}};
      cur_idx_r <= 6'h00;
      uses_r <= 9'h0;
      st_repeat_cur <= `REPEAT_RST;
      stop_pend_r <= 1'b0;
      in_frame_r <= 1'b0;
      run_r <= 1'b0;
      load_pend_r <= 1'b0;
      load_idx_r <= 6'h00;
      sw_cmd_r <= 3'h0;
      frame_tag_r <= 6'h00;
      frame_tag_valid_r <= 1'b0;
    end else begin
      frame_tag_valid_r <= 1'b0;
      // frame tracking
      if (frame_start)
        in_frame_r <= 1'b1;
      else if (frame_done)
        in_frame_r <= 1'b0;
      // tag the frame with the set that acquires it
      if (frame_start && tag_en_r) begin
        frame_tag_valid_r <= 1'b1;
        frame_tag_r <= do_load ? tgt : cur_idx_r;
      end
      // use counting; a scheme or command load on a frame trigger restarts it at one, the enable load or a command load off a trigger restarts it at zero
      if (do_load) begin
        load_pend_r <= 1'b1;
        load_idx_r <= tgt;
        uses_r <= (frame_start && !en_rise) ? 9'h001 : 9'h000;
      end else if (run_r && frame_start && uses_r != 9'h1FF) begin
        uses_r <= uses_r + 9'h001;
      end
      // apply a set once read out of the store
      if (load_pend_r) begin
        load_pend_r <= 1'b0;
        active_param_r <= st_param;
        st_repeat_cur <= st_repeat;
        cur_idx_r <= load_idx_r;
      end
      if (clr_sw)
        sw_cmd_r <= 3'h0;
      // register writes
      if (wr) begin
        case (addr)
          `ADDR_CTRL: begin
            mode_r <= wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
            src_r <= wdata[`CTRL_SRC_HI:`CTRL_SRC_LO];
            tag_en_r <= wdata[`CTRL_TAG];
            rst_line_r <= wdata[`CTRL_RST_LINE+2:`CTRL_RST_LINE];
            if (en_rise) begin
              en_r <= 1'b1;
              run_r <= 1'b1;
              saved_r <= active_param_r;
            end else if (!wdata[`CTRL_EN] && en_r) begin
              en_r <= 1'b0;
              stop_pend_r <= 1'b1;
            end
          end
          `ADDR_COUNT: begin
            if (wdata[6:0] == 7'h00)
              count_r <= `COUNT_RST;
            else if (wdata[31:0] > {25'h0, `MAX_SETS})
              count_r <= `MAX_SETS;
            else
              count_r <= wdata[6:0];
          end
          `ADDR_SEL: sel_r <= wdata[5:0];
          `ADDR_REPEAT: rep_hold_r <= clamp_rep(wdata);
          `ADDR_PARAM: param_hold_r <= wdata[DW-1:0];
          `ADDR_CMD: begin
            if (en_r)
              sw_cmd_r <= sw_cmd_r | {wdata[`CMD_SKIP],
                wdata[`CMD_RESTART], wdata[`CMD_ADVANCE]};
            else if (wdata[`CMD_RECALL]) begin
              load_pend_r <= 1'b1;
              load_idx_r <= sel_r;
            end
          end
          default: ;
        endcase
      end
      // stop after the open frame has been sent, restore old values
      if (stop_pend_r && (!in_frame_r || frame_done) && !load_pend_r) begin
        stop_pend_r <= 1'b0;
        run_r <= 1'b0;
        sw_cmd_r <= 3'h0;
        active_param_r <= saved_r;
      end
    end
  end

  // read mux, data one cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `ADDR_CTRL: rdata <= {23'h0, rst_line_r, tag_en_r, src_r,
                               mode_r, en_r};
        `ADDR_COUNT: rdata <= {25'h0, count_r};
        `ADDR_SEL: rdata <= {26'h0, sel_r};
        `ADDR_REPEAT: rdata <= {23'h0, rep_hold_r};
        `ADDR_STATUS: rdata <= {14'h0, stop_pend_r, run_r, uses_r,
                                 cur_idx_r, 1'b0};
        `ADDR_PARAM: rdata <= param_hold_r;
        `ADDR_ACTIVE: rdata <= en_r ? saved_r : active_param_r;
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // line_sel kept for readability of source decode
  wire unused_ok = &{1'b0, line_sel};
endmodule // param_set_sequencer
`default_nettype wire

// ---- sim/param_set_sequencer_props.sv ----
/*
  port checker for the parameter set sequencer.
  assumes: bound to the top module, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module param_set_sequencer_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // inputs watched
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic wr,
  input wire logic rd,
  // outputs watched
  input wire logic [31:0] rdata,
  input wire logic [31:0] active_param_r,
  input wire logic [5:0] cur_idx_r,
  input wire logic [5:0] frame_tag_r,
  input wire logic frame_tag_valid_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a set change needs a trigger, a command or a frame end
  // software commands land three edges after their write
  a_idx_change_cause: assert property (
    $changed(cur_idx_r) |-> $past(frame_start, 2) || $past(wr) ||
    $past(wr, 2) || $past(wr, 3) || $past(frame_done) ||
    $past(frame_done, 2))
    else $error("set index moved without cause");
  // active word only moves after a load or the restore at disable
  a_active_change_cause: assert property (
    $changed(active_param_r) |-> $past(frame_start, 2) || $past(wr) ||
    $past(wr, 2) || $past(wr, 3) || $past(frame_done) ||
    $past(frame_done, 2))
    else $error("active word moved without cause");
  // quiet lines and bus keep the active word
  a_quiet_hold: assert property (
    (!frame_start && !wr && !frame_done) [*4] |-> $stable(active_param_r))
    else $error("active word changed while idle");
  // without a command the set may move only after a trigger or a frame end
  a_lines_sync: assert property (
    $changed(cur_idx_r) && !$past(wr) && !$past(wr, 2) &&
    !$past(wr, 3) |->
    $past(frame_start, 2) || $past(frame_done) || $past(frame_done, 2))
    else $error("set index moved off a trigger");
  a_tag_after_start: assert property (
    frame_tag_valid_r |-> $past(frame_start))
    else $error("tag without frame trigger");
  a_tag_single: assert property (
    frame_tag_valid_r |=> !frame_tag_valid_r)
    else $error("tag pulse too long");
  // tag names the set that governs the frame
  a_tag_sets_idx: assert property (
    frame_tag_valid_r |=> cur_idx_r == $past(frame_tag_r))
    else $error("tag differs from set used");
  a_rdata_after_read: assert property (
    rdata != 32'h0 |-> $past(rd))
    else $error("read data outside read slot");
endmodule // param_set_sequencer_props
`default_nettype wire

// ---- sim/frame_source.sv ----
/*
  frame trigger partner: a trigger pulse per kick, frame end two
  cycles later.
  assumes: kicks at least six cycles apart.
*/
`timescale 1ns/100ps
`default_nettype none
module frame_source (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic kick,
  // frame pulses
  output logic frame_start,
  output logic frame_done
);
  logic [2:0] age_r = 3'h0; // frame age shift
  // whole frames only, trigger and end always paired
  always @(posedge clk) begin
    age_r <= {age_r[1:0], kick};
  end
  assign frame_start = age_r[0];
  assign frame_done = age_r[2];
endmodule // frame_source
`default_nettype wire

// ---- sim/param_set_sequencer_tb.sv ----
/*
  bench for the parameter set sequencer: registers, auto scheme,
  skip, restart, recall, disable, controlled and free schemes.
  assumes: frame_source partner and the props checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "param_seq_map.vh"
module param_set_sequencer_tb;
  logic clk, reset, kick, wr, rd;
  logic [5:0] in_lines, cur_idx_r, frame_tag_r, tag_seen;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, active_param_r;
  logic frame_tag_valid_r;
  wire logic frame_start, frame_done;
  int miscompares = 0, n_compared = 0, cyc = 0;
  // expected set after each auto frame, repeats 1,2,1 over 3 sets
  logic [5:0] rows [6] = '{6'h0, 6'h1, 6'h1, 6'h2, 6'h0, 6'h1};

  frame_source i_frame_source (.clk(clk), .kick(kick),
    .frame_start(frame_start), .frame_done(frame_done));
  param_set_sequencer i_param_set_sequencer (.clk(clk), .reset(reset),
    .frame_start(frame_start), .frame_done(frame_done),
    .in_lines(in_lines), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .active_param_r(active_param_r),
    .cur_idx_r(cur_idx_r), .frame_tag_r(frame_tag_r),
    .frame_tag_valid_r(frame_tag_valid_r));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard and tag capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (frame_tag_valid_r === 1'b1) tag_seen <= frame_tag_r;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // wait n edges, then sample settled outputs
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write, one idle cycle so strobes never merge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string w, input logic [7:0] a,
                      input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(w, e, rdata);
    @(posedge clk);
  endtask
  task automatic frame(input logic [5:0] lines);
    in_lines <= lines;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wait_n(6);
  endtask
  task automatic idx_is(input logic [5:0] e);
    chk("index", {26'h0, e}, {26'h0, cur_idx_r});
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    kick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    in_lines = 6'h00;
    addr = 8'h00;
    wdata = 32'h0;
    wait_n(12);
    reset <= 1'b0;
    wait_n(1);
    chk("active rst", 32'h0, active_param_r);
    rchk("count rst", `ADDR_COUNT, 32'h1);
    rchk("ctrl rst", `ADDR_CTRL, 32'h40);
    wreg(`ADDR_REPEAT, 32'h0);
    rchk("repeat lo", `ADDR_REPEAT, 32'h1);
    wreg(`ADDR_REPEAT, 32'h1FF);
    rchk("repeat hi", `ADDR_REPEAT, 32'h100);
    wreg(`ADDR_COUNT, 32'h7F);
    rchk("count hi", `ADDR_COUNT, 32'h40);
    wreg(`ADDR_COUNT, 32'h3);
    // three sets, word A0+i, repeats 1,2,1
    for (int i = 0; i < 3; i++) begin
      wreg(`ADDR_SEL, i);
      wreg(`ADDR_PARAM, 32'hA0 + i);
      wreg(`ADDR_REPEAT, (i == 1) ? 32'h2 : 32'h1);
      wreg(`ADDR_CMD, 32'h10);
    end
    wreg(`ADDR_SEL, 32'h2);
    wreg(`ADDR_CMD, 32'h8);
    wait_n(2);
    chk("recall", 32'hA2, active_param_r);
    wreg(`ADDR_CTRL, 32'h21);
    wait_n(2);
    idx_is(6'h0);
    chk("enable", 32'hA0, active_param_r);
    foreach (rows[i]) begin
      frame(6'h00);
      idx_is(rows[i]);
      chk("active", 32'hA0 + rows[i], active_param_r);
      chk("tag", {26'h0, rows[i]}, {26'h0, tag_seen});
    end
    wreg(`ADDR_CMD, 32'h4);
    wait_n(2);
    idx_is(6'h0);
    frame(6'h00);
    idx_is(6'h0);
    frame(6'h00);
    idx_is(6'h1);
    wreg(`ADDR_CMD, 32'h2);
    wait_n(2);
    idx_is(6'h0);
    wreg(`ADDR_CTRL, 32'h0);
    wait_n(2);
    chk("restore", 32'hA2, active_param_r);
    // controlled, gate on line 0, restart on line 5
    wreg(`ADDR_CTRL, 32'h14B);
    wait_n(2);
    rchk("active en", `ADDR_ACTIVE, 32'hA2);
    frame(6'h00);
    frame(6'h00);
    idx_is(6'h0);
    frame(6'h01);
    idx_is(6'h1);
    wait_n(8);
    idx_is(6'h1);
    frame(6'h20);
    idx_is(6'h0);
    wreg(`ADDR_CTRL, 32'h0);
    wreg(`ADDR_CTRL, 32'h05);
    in_lines <= 6'h02;
    wait_n(4);
    idx_is(6'h0);
    frame(6'h02);
    idx_is(6'h2);
    frame(6'h05);
    idx_is(6'h0);
    // second reset in mid-run
    reset <= 1'b1;
    wait_n(2);
    reset <= 1'b0;
    wait_n(1);
    idx_is(6'h0);
    chk("active rst2", 32'h0, active_param_r);
    conclude();
  end
endmodule // param_set_sequencer_tb

bind param_set_sequencer param_set_sequencer_props
  i_param_set_sequencer_props (.clk(clk), .reset(reset),
  .frame_start(frame_start), .frame_done(frame_done), .wr(wr),
  .rd(rd), .rdata(rdata), .active_param_r(active_param_r),
  .cur_idx_r(cur_idx_r), .frame_tag_r(frame_tag_r),
  .frame_tag_valid_r(frame_tag_valid_r));
`default_nettype wire
